//--- inc/tws_cfg.svh
// constants of the three-wire serial configuration port: frame layout,
// bit positions, reset values and serial clock timing.
// assumes inclusion by bare name from the package and the design modules.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// field widths
`define TWS_ADDR_W       13
`define TWS_DATA_W       8
`define TWS_CNT_W        5

// frame bit positions, counted from the first bit on the line
`define TWS_BIT_RW       5'h00
`define TWS_BIT_MB_HIGH  5'h01
`define TWS_BIT_MB_LOW   5'h02
`define TWS_BIT_ADDR_END 5'h0F
`define TWS_BIT_DATA_1ST 5'h10
`define TWS_BIT_LAST     5'h17
`define TWS_FRAME_LEN    5'h18

// frame field positions inside the host's shift word
`define TWS_POS_RW       23
`define TWS_MB_IDLE      2'h0

// register file
`define TWS_NREG         16
`define TWS_REG_RST      8'h00
`define TWS_RD_UNMAPPED  8'h00

// serial clock: half period in system clock cycles
`define TWS_CLK_PERIOD_NS 25
`define TWS_DIV_HALF      3
`define TWS_DIV_MIN       3
`define TWS_LINE_IDLE     1'h1

`endif

//--- inc/tws_pkg.sv
// types shared by both ends of the three-wire serial configuration port.
// assumes tws_cfg.svh is on the include path.
`include "tws_cfg.svh"

package tws_pkg;

	typedef logic [`TWS_ADDR_W-1:0] tws_addr_t;
	typedef logic [`TWS_DATA_W-1:0] tws_byte_t;
	typedef logic [`TWS_CNT_W-1:0]  tws_cnt_t;

	// host sequencer, gray along idle-wait-shift-gap
	typedef enum logic [1:0] {
		hs_idle  = 2'h0,
		hs_wait  = 2'h1,
		hs_shift = 2'h3,
		hs_gap   = 2'h2
	} tws_hstate_t;

endpackage

//--- inc/tws_if.sv
// three-wire link between host end and device end.
// the shared data line is resolved here from both enables; an undriven
// line reads high, and the host wins if both drive.
`timescale 1ns/100ps
`include "tws_cfg.svh"

interface tws_if;
	logic sclk;
	logic port_frame_enable;
	logic host_sdo;
	logic host_oe;
	logic dev_sdo;
	logic dev_oe;
	logic serial_io_line;

	// wired level of the bidirectional data line
	assign serial_io_line = host_oe ? host_sdo :
		(dev_oe ? dev_sdo : `TWS_LINE_IDLE);

	modport host (
		output sclk,
		output port_frame_enable,
		output host_sdo,
		output host_oe,
		input  serial_io_line
	);

	modport dev (
		input  sclk,
		input  port_frame_enable,
		input  serial_io_line,
		output dev_sdo,
		output dev_oe
	);
endinterface

//--- rtl/tws_sync.sv
// two flip-flop synchroniser for one level into the clk domain.
// assumes d is a level held long enough to be seen.
`timescale 1ns/100ps

module tws_sync (
	// clock
	input  wire logic clk,
	// crossing level
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

//--- rtl/tws_dev.sv
// device end of the three-wire serial configuration port with its
// register file; link logic runs on the serial clock, write notices
// cross to the system clock.
// assumes the host keeps the serial clock toggling for at least one
// period after the frame enable drops.
//
// Operation
// (R01) 24-bit frame MSB first: rw, mb, addr, data
// (R02) three signals: enable, shared data, serial clock
// (R03) first rising edge after enable captures rw
// (R04) first bit one means read
// (R05) first bit zero means write
// (R06) host drives both multibyte bits zero
// (R07) device samples two multibyte bits next
// (R08) host sends 13 address bits MSB first
// (R09) device shifts in 13 address bits
// (R10) read: device drives 8 data bits falling
// (R11) read: host releases line, samples rising
// (R12) write: host drives 8 data bits falling
// (R13) write: device shifts in 8 data bits
// (R14) last rising edge loads addressed register
// (R15) enable drop ends frame, device waits again
// (R16) write to undefined address changes nothing
// (R17) short frame discarded, no update, line released
// (R18) device drives line only in read data
`timescale 1ns/100ps
`include "tws_cfg.svh"

module tws_dev
	import tws_pkg::*;
#(
	parameter int NREG = `TWS_NREG
) (
	// link, device side
	tws_if.dev             link,
	// system clock and reset
	input  wire logic      clk,
	input  wire logic      sys_rst,
	// register write notices, clk domain
	output logic           cfg_wr_pulse,
	output tws_addr_t      cfg_wr_addr,
	output tws_byte_t      cfg_wr_data
);
	localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

	// refuse register counts the address field cannot reach
	generate
		if (NREG < 1 || NREG > (1 << `TWS_ADDR_W)) begin : g_bad
			$error("tws_dev: NREG out of range");
		end
	endgenerate

	// link domain state
	logic                  lrst;
	tws_cnt_t              bit_cnt_r;
	logic [`TWS_ADDR_W-2:0] shift_r;
	logic                  rw_r;
	logic                  multibyte_bit_high_r;
	logic                  multibyte_bit_low_r;
	tws_addr_t             addr_r;
	tws_byte_t             regs_r [NREG];
	logic                  sdo_r;
	logic                  oe_r;
	logic                  wr_tgl_r;
	tws_addr_t             wr_addr_r;
	tws_byte_t             wr_data_r;

	// system domain state
	logic                  wr_tgl_s;
	logic                  wr_tgl_d_r;
	logic                  wr_pulse_r;
	tws_addr_t             wr_addr_s_r;
	tws_byte_t             wr_data_s_r;

	// frame bit on the line and frame activity
	logic                  sdi;
	logic                  in_frame;
	logic                  last_edge;
	tws_byte_t             rx_byte;
	tws_byte_t             rd_byte;

	// address maps onto a defined register
	function automatic logic addr_ok(input tws_addr_t a);
		addr_ok = (32'(a) < NREG);
	endfunction

	// register index from a frame address
	function automatic logic [IW-1:0] reg_idx(input tws_addr_t a);
		reg_idx = a[IW-1:0];
	endfunction

	// data bit number for a given frame position
	function automatic logic [2:0] data_sel(input tws_cnt_t c);
		tws_cnt_t d;
		d = `TWS_BIT_LAST - c;
		data_sel = d[2:0];
	endfunction

	// system reset carried into the link clock domain
	tws_sync u_rst_sync (
		.clk (link.sclk),
		.d   (sys_rst),
		.q   (lrst)
	);

	assign sdi       = link.serial_io_line;
	assign in_frame  = link.port_frame_enable && !lrst;
	assign last_edge = in_frame && (bit_cnt_r == `TWS_BIT_LAST);
	assign rx_byte   = {shift_r[`TWS_DATA_W-2:0], sdi};
	assign rd_byte   = addr_ok(addr_r) ? regs_r[reg_idx(addr_r)]
		: `TWS_RD_UNMAPPED;

	// bit position in the frame, cleared while enable is low
	always_ff @(posedge link.sclk) begin
		if (!in_frame) begin
			bit_cnt_r <= `TWS_BIT_RW;  // [R15] [R17]
		end else if (bit_cnt_r < `TWS_FRAME_LEN) begin
			bit_cnt_r <= bit_cnt_r + 5'h01;  // [R01]
		end
	end

	// serial input shift, MSB first
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			shift_r <= '0;
		end else if (in_frame && bit_cnt_r < `TWS_FRAME_LEN) begin
			shift_r <= {shift_r[`TWS_ADDR_W-3:0], sdi};  // [R09] [R13]
		end
	end

	// direction flag from the first bit of the frame
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			rw_r <= 1'h0;
		end else if (in_frame && bit_cnt_r == `TWS_BIT_RW) begin
			rw_r <= sdi;  // [R03] [R04] [R05]
		end
	end

	// multibyte field, sampled and kept for reference
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			multibyte_bit_high_r <= 1'h0;
			multibyte_bit_low_r  <= 1'h0;
		end else if (in_frame) begin
			if (bit_cnt_r == `TWS_BIT_MB_HIGH) begin
				multibyte_bit_high_r <= sdi;  // [R07]
			end
			if (bit_cnt_r == `TWS_BIT_MB_LOW) begin
				multibyte_bit_low_r <= sdi;  // [R07]
			end
		end
	end

	// address latched on its thirteenth bit
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			addr_r <= '0;
		end else if (in_frame && bit_cnt_r == `TWS_BIT_ADDR_END) begin
			addr_r <= {shift_r, sdi};  // [R09]
		end
	end

	// register file, loaded on the last rising edge of a write
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			for (int i = 0; i < NREG; i++) begin
				regs_r[i] <= `TWS_REG_RST;
			end
		end else if (last_edge && !rw_r && addr_ok(addr_r)) begin
			regs_r[reg_idx(addr_r)] <= rx_byte;  // [R14] [R16]
		end
	end

	// write notice held for the crossing; toggle marks the event
	always_ff @(posedge link.sclk) begin
		if (lrst) begin
			wr_tgl_r  <= 1'h0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
		end else if (last_edge && !rw_r && addr_ok(addr_r)) begin
			wr_tgl_r  <= !wr_tgl_r;  // [R16]
			wr_addr_r <= addr_r;
			wr_data_r <= rx_byte;
		end
	end

	// read data launched on falling edges, line released otherwise
	always_ff @(negedge link.sclk) begin
		if (!in_frame || !rw_r ||
			bit_cnt_r < `TWS_BIT_DATA_1ST ||
			bit_cnt_r > `TWS_BIT_LAST) begin
			oe_r  <= 1'h0;  // [R17] [R18]
			sdo_r <= `TWS_LINE_IDLE;
		end else begin
			oe_r  <= 1'h1;  // [R10] [R18]
			sdo_r <= rd_byte[data_sel(bit_cnt_r)];  // [R10]
		end
	end

	assign link.dev_sdo = sdo_r;
	assign link.dev_oe  = oe_r;  // [R02]

	// write toggle into the system clock domain
	tws_sync u_wr_sync (
		.clk (clk),
		.d   (wr_tgl_r),
		.q   (wr_tgl_s)
	);

	// toggle edge turns into a one-cycle notice
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_tgl_d_r <= 1'h0;
			wr_pulse_r <= 1'h0;
		end else begin
			wr_tgl_d_r <= wr_tgl_s;
			wr_pulse_r <= wr_tgl_s ^ wr_tgl_d_r;
		end
	end

	// notice payload, stable for many cycles around the toggle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_addr_s_r <= '0;
			wr_data_s_r <= '0;
		end else if (wr_tgl_s ^ wr_tgl_d_r) begin
			wr_addr_s_r <= wr_addr_r;
			wr_data_s_r <= wr_data_r;
		end
	end

	assign cfg_wr_pulse = wr_pulse_r;
	assign cfg_wr_addr  = wr_addr_s_r;
	assign cfg_wr_data  = wr_data_s_r;
endmodule

//--- rtl/tws_host.sv
// host end of the three-wire serial configuration port: makes the
// serial clock by dividing clk and runs one 24-bit frame per request.
// assumes the device answers on the falling edges this end produces.
`timescale 1ns/100ps
`include "tws_cfg.svh"

module tws_host
	import tws_pkg::*;
#(
	parameter int DIV_HALF = `TWS_DIV_HALF
) (
	// system clock and reset
	input  wire logic      clk,
	input  wire logic      sys_rst,
	// link, host side
	tws_if.host            link,
	// request
	input  wire logic      req_valid,
	output logic           req_ready,
	input  wire logic      req_read,
	input  tws_addr_t      req_addr,
	input  tws_byte_t      req_wdata,
	// answer
	output logic           resp_valid,
	output tws_byte_t      resp_rdata
);
	// read sampling lags two sync stages; half period must cover them
	generate
		if (DIV_HALF < `TWS_DIV_MIN || DIV_HALF > 256) begin : g_bad
			$error("tws_host: DIV_HALF out of range");
		end
	endgenerate

	localparam logic [7:0] DIV_LAST = 8'(DIV_HALF - 1);

	logic [7:0]            div_r;
	logic                  sclk_r;
	logic                  tick;
	logic                  fall_ev;
	logic                  rise_ev;
	logic                  sdi_s;
	tws_hstate_t           state_r;
	logic [`TWS_POS_RW:0]  sh_r;
	tws_cnt_t              bit_r;
	logic                  rd_r;
	logic                  en_r;
	logic                  sdo_r;
	logic                  oe_r;
	logic                  ready_r;
	logic                  resp_r;
	tws_byte_t             rx_r;
	tws_byte_t             rdata_r;
	logic                  in_data;

	// free-running serial clock from the divider
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_r  <= 8'h00;
			sclk_r <= 1'h0;
		end else if (tick) begin
			div_r  <= 8'h00;
			sclk_r <= !sclk_r;
		end else begin
			div_r  <= div_r + 8'h01;
		end
	end

	assign tick    = (div_r == DIV_LAST);
	assign fall_ev = tick && sclk_r;
	assign rise_ev = tick && !sclk_r;
	assign in_data = rd_r && (bit_r >= `TWS_BIT_DATA_1ST);

	// returned data line into the clk domain
	tws_sync u_sdi_sync (
		.clk (clk),
		.d   (link.serial_io_line),
		.q   (sdi_s)
	);

	// frame sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= hs_idle;
			sh_r    <= '0;
			bit_r   <= `TWS_BIT_RW;
			rd_r    <= 1'h0;
			en_r    <= 1'h0;
			sdo_r   <= `TWS_LINE_IDLE;
			oe_r    <= 1'h0;
			ready_r <= 1'h1;
			resp_r  <= 1'h0;
			rx_r    <= '0;
			rdata_r <= '0;
		end else begin
			resp_r <= 1'h0;
			case (state_r)
				hs_idle: begin
					if (req_valid && ready_r) begin
						sh_r    <= {req_read, `TWS_MB_IDLE, req_addr,
							req_wdata};  // [R01] [R06] [R08] [R12]
						rd_r    <= req_read;
						ready_r <= 1'h0;
						state_r <= hs_wait;
					end
				end
				hs_wait: begin
					if (fall_ev) begin
						en_r    <= 1'h1;  // [R04] [R05]
						oe_r    <= 1'h1;
						sdo_r   <= sh_r[`TWS_POS_RW];
						sh_r    <= {sh_r[`TWS_POS_RW-1:0], 1'h0};
						bit_r   <= `TWS_BIT_RW;
						state_r <= hs_shift;
					end
				end
				hs_shift: begin
					if (rise_ev) begin
						bit_r <= bit_r + 5'h01;
						if (in_data) begin
							rx_r <= {rx_r[`TWS_DATA_W-2:0], sdi_s};  // [R11]
						end
					end
					if (fall_ev) begin
						if (bit_r == `TWS_FRAME_LEN) begin
							en_r    <= 1'h0;  // [R15]
							oe_r    <= 1'h0;
							sdo_r   <= `TWS_LINE_IDLE;
							resp_r  <= 1'h1;
							rdata_r <= rd_r ? rx_r : `TWS_RD_UNMAPPED;
							state_r <= hs_gap;
						end else begin
							oe_r  <= !in_data;  // [R11]
							sdo_r <= sh_r[`TWS_POS_RW];
							sh_r  <= {sh_r[`TWS_POS_RW-1:0], 1'h0};
						end
					end
				end
				hs_gap: begin
					// a full idle period lets the device see enable low
					if (fall_ev) begin
						ready_r <= 1'h1;
						state_r <= hs_idle;
					end
				end
				default: begin
					state_r <= hs_idle;
				end
			endcase
		end
	end

	assign link.sclk              = sclk_r;
	assign link.port_frame_enable = en_r;  // [R02]
	assign link.host_sdo          = sdo_r;
	assign link.host_oe           = oe_r;
	assign req_ready              = ready_r;
	assign resp_valid             = resp_r;
	assign resp_rdata             = rdata_r;
endmodule

//--- verification/tws_link_checker.sv
// link checker for the three-wire port: frame length, line ownership
// and read data phase, sampled on rising serial clock edges.
// assumes the interface signals of the host-to-device link as inputs.
`timescale 1ns/100ps

module tws_link_checker (
	// reset
	input wire logic sys_rst,
	// link
	input wire logic sclk,
	input wire logic port_frame_enable,
	input wire logic host_sdo,
	input wire logic host_oe,
	input wire logic dev_sdo,
	input wire logic dev_oe,
	input wire logic serial_io_line
);
	logic [4:0] cnt_r;
	logic       rw_r;

	default clocking cb @(posedge sclk); endclocking
	default disable iff (sys_rst);

	// rising edges seen inside the current frame
	always_ff @(posedge sclk) begin
		if (sys_rst || !port_frame_enable)
			cnt_r <= 5'h00;
		else
			cnt_r <= cnt_r + 5'h01;
	end

	// direction flag of the current frame
	always_ff @(posedge sclk) begin
		if (port_frame_enable && cnt_r == 5'h00)
			rw_r <= serial_io_line;
	end

	sequence s_dev_drive;
		dev_oe [*8] ##1 !dev_oe;
	endsequence

	AST_OE_EXCL: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the data line");
	AST_FIRST_BIT: assert property ($rose(port_frame_enable) |->
		host_oe && serial_io_line == host_sdo)
		else $error("first bit not driven by host");
	AST_MB_ZERO: assert property (port_frame_enable &&
		(cnt_r == 5'h01 || cnt_r == 5'h02) |-> !serial_io_line)
		else $error("multibyte bit not zero");
	AST_ADDR_HOST: assert property (port_frame_enable &&
		cnt_r < 5'h10 |-> host_oe)
		else $error("host not driving header");
	AST_WR_DATA: assert property (port_frame_enable && !rw_r &&
		cnt_r >= 5'h10 |-> host_oe && !dev_oe)
		else $error("host not driving write data");
	AST_RD_DATA: assert property (port_frame_enable && rw_r &&
		cnt_r >= 5'h10 |-> !host_oe && dev_oe && serial_io_line == dev_sdo)
		else $error("device not driving read data");
	AST_RD_EIGHT: assert property ($rose(dev_oe) |-> s_dev_drive)
		else $error("read data phase not eight bits");
	AST_FRAME_LEN: assert property ($fell(port_frame_enable) |->
		cnt_r == 5'h18)
		else $error("frame not 24 bits");
	AST_IDLE_FREE: assert property (!port_frame_enable |->
		!host_oe && !dev_oe && serial_io_line)
		else $error("line driven outside a frame");
endmodule

//--- verification/tws_tb_top.sv
// testbench: host end and device end joined by one link, plus a second
// device driven directly by the bench to cut a frame short.
// assumes the package, interface and both ends are compiled first.
`timescale 1ns/100ps

module tws_tb_top
	import tws_pkg::*;
;
	logic      clk;
	logic      rst_h;
	logic      rst_d;
	logic      req_valid;
	logic      req_ready;
	logic      req_read;
	tws_addr_t req_addr;
	tws_byte_t req_wdata;
	logic      resp_valid;
	tws_byte_t resp_rdata;
	logic      wr_pulse;
	tws_addr_t wr_addr;
	tws_byte_t wr_data;
	logic      wr2_pulse;
	tws_addr_t wr2_addr;
	tws_byte_t wr2_data;
	int        fail_count;
	int        samples_checked;
	int        cyc;
	int        wr_n;
	int        wr2_n;
	tws_byte_t q;
	tws_byte_t exp_r [16];

	tws_if link ();
	tws_if link2 ();

	tws_host tws_host_i (.clk(clk), .sys_rst(rst_h), .link(link),
		.req_valid(req_valid), .req_ready(req_ready),
		.req_read(req_read), .req_addr(req_addr),
		.req_wdata(req_wdata), .resp_valid(resp_valid),
		.resp_rdata(resp_rdata));
	tws_dev tws_dev_i (.link(link), .clk(clk), .sys_rst(rst_d),
		.cfg_wr_pulse(wr_pulse), .cfg_wr_addr(wr_addr),
		.cfg_wr_data(wr_data));
	tws_dev tws_dev_i2 (.link(link2), .clk(clk), .sys_rst(rst_d),
		.cfg_wr_pulse(wr2_pulse), .cfg_wr_addr(wr2_addr),
		.cfg_wr_data(wr2_data));
	tws_link_checker tws_link_checker_i (.sys_rst(rst_d),
		.sclk(link.sclk), .port_frame_enable(link.port_frame_enable),
		.host_sdo(link.host_sdo), .host_oe(link.host_oe),
		.dev_sdo(link.dev_sdo), .dev_oe(link.dev_oe),
		.serial_io_line(link.serial_io_line));

	// system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// write notice counters and cycle ceiling
	always @(posedge clk) begin
		cyc++;
		if (wr_pulse === 1'b1)
			wr_n++;
		if (wr2_pulse === 1'b1)
			wr2_n++;
		if (cyc == 30000) begin
			fail_count++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one host transfer; returns the answer byte
	task automatic xfer(input logic rd, input tws_addr_t a,
		input tws_byte_t d, output tws_byte_t r);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		req_valid = 1'b1;
		req_read = rd;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		n = 0;
		while (resp_valid !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(32'(n < 400), 32'h1);
		r = resp_rdata;
		repeat (8) @(posedge clk);
		#1;
	endtask

	// bench-made frame into the second device, cut after nb bits
	task automatic frame2(input logic [23:0] f, input int nb);
		link2.port_frame_enable = 1'b1;
		link2.host_oe = 1'b1;
		for (int i = 23; i > 23 - nb; i--) begin
			link2.host_sdo = f[i];
			// line let go for the data bits of a read
			link2.host_oe = !(f[23] && i < 8);
			#24 link2.sclk = 1'b1;
			#24 link2.sclk = 1'b0;
		end
		link2.port_frame_enable = 1'b0;
		link2.host_oe = 1'b0;
		link2.host_sdo = ~link2.host_sdo;
		repeat (2) begin
			#24 link2.sclk = 1'b1;
			#24 link2.sclk = 1'b0;
		end
		repeat (8) @(posedge clk);
		#1;
	endtask

	initial begin
		{fail_count, samples_checked, cyc, wr_n, wr2_n} = '0;
		{rst_h, rst_d, req_valid, req_read} = 4'hF;
		req_addr = '0;
		req_wdata = '0;
		link2.sclk = 1'b0;
		link2.port_frame_enable = 1'b0;
		link2.host_oe = 1'b0;
		link2.host_sdo = 1'b1;
		req_valid = 1'b0;
		foreach (exp_r[i])
			exp_r[i] = 8'h00;
		repeat (5) @(posedge clk);
		#1 rst_h = 1'b0;
		// second device link clock runs ten periods during its reset
		repeat (10) begin
			#24 link2.sclk = 1'b1;
			#24 link2.sclk = 1'b0;
		end
		repeat (150) @(posedge clk);
		#1 rst_d = 1'b0;
		// let both device link resets clear before the first frame
		repeat (3) begin
			#24 link2.sclk = 1'b1;
			#24 link2.sclk = 1'b0;
		end
		repeat (20) @(posedge clk);
		#1;
		xfer(1'b1, 13'h0000, 8'h00, q);
		check(32'(q), 32'h00);
		// writes with notices, then read back
		for (int k = 0; k < 3; k++) begin
			automatic tws_addr_t a = (k == 0) ? 13'h0003 :
				(k == 1) ? 13'h0000 : 13'h000F;
			automatic tws_byte_t d = (k == 0) ? 8'hA5 :
				(k == 1) ? 8'h5A : 8'hC3;
			xfer(1'b0, a, d, q);
			exp_r[a[3:0]] = d;
			check(32'(wr_n), 32'(k + 1));
			check({11'h000, wr_addr, wr_data}, {11'h000, a, d});
		end
		for (int k = 15; k >= 0; k--) begin
			xfer(1'b1, 13'(k), 8'hFF, q);
			check(32'(q), 32'(exp_r[k]));
		end
		// unmapped writes change nothing
		xfer(1'b0, 13'h0010, 8'hFF, q);
		xfer(1'b0, 13'h1FFF, 8'h77, q);
		check(32'(wr_n), 32'h3);
		xfer(1'b1, 13'h0010, 8'h00, q);
		check(32'(q), 32'h00);
		xfer(1'b1, 13'h0003, 8'h00, q);
		check(32'(q), 32'hA5);
		// short frame dropped, next full frame accepted
		frame2({1'b0, 2'h0, 13'h0002, 8'h99}, 20);
		check(32'(wr2_n), 32'h0);
		check(32'(link2.dev_oe), 32'h0);
		// read cut inside its data phase releases the line
		frame2({1'b1, 2'h0, 13'h0005, 8'h00}, 20);
		check(32'(link2.dev_oe), 32'h0);
		check(32'(wr2_n), 32'h0);
		frame2({1'b0, 2'h0, 13'h0005, 8'h3C}, 24);
		check(32'(wr2_n), 32'h1);
		check({11'h000, wr2_addr, wr2_data}, {11'h000, 13'h0005, 8'h3C});
		results();
	end
endmodule
